/* File: sim/aoncp_board_model.sv */
/*
  Board model: supply rails switched by the two supply outputs, the
  clock-select pad and the wake buttons.
  Assumes it shares the slow always-on clock with the controller.
*/
`timescale 1ns/1ps
module aoncp_board_model #(
  parameter int WAKE_W = 2,
  parameter int RAMP_CYC = 3
) (
  input wire logic sys_clk,
  input wire logic pmu_out_0,
  input wire logic pmu_out_1,
  input wire logic pad_low,
  input wire logic [WAKE_W-1:0] wake_btn,
  output logic clksel_pad,
  output logic [WAKE_W-1:0] wake_pad,
  output logic core_rail_ok,
  output logic pad_rail_ok
);
  int core_cnt = 0;
  int pad_cnt = 0;

  // strap pad: low asks for the external slow clock
  assign clksel_pad = ~pad_low;
  assign wake_pad = wake_btn;

  // rails ramp for RAMP_CYC cycles after enable, drop on the first clock edge after they are switched off
  always @(posedge sys_clk) begin
    if (!pmu_out_0) core_cnt <= 0;
    else if (core_cnt < RAMP_CYC) core_cnt <= core_cnt + 1;
    if (!pmu_out_1) pad_cnt <= 0;
    else if (pad_cnt < RAMP_CYC) pad_cnt <= pad_cnt + 1;
  end
  assign core_rail_ok = (core_cnt == RAMP_CYC);
  assign pad_rail_ok = (pad_cnt == RAMP_CYC);
endmodule // aoncp_board_model

/* File: sim/tb.sv */
/*
  Self-checking bench of the always-on clock and power controller.
  Assumes the register port, stage counts shortened by parameters.
*/
`timescale 1ns/1ps
`include "aoncp_consts.svh"
module tb;
  import aoncp_pkg::*;
  localparam int OSC_N = 8;
  localparam int STG_N = 4;
  localparam int LIMIT = 3000;
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic wfi_exec = 1'b0;
  logic [2:0] irq_src = 3'h0;
  logic pad_low = 1'b0;
  logic [1:0] wake_btn = 2'h0;
  logic [31:0] reg_rdata, rd_val;
  logic [1:0] wake_pad;
  logic [5:0] slow_osc_div;
  logic [4:0] slow_osc_trim;
  logic clksel_pad, pipe_clk_gate, slow_osc_en, slow_clk_use_ext;
  logic fast_osc_default, pmu_out_0, pmu_out_1, clk_rst, core_rst;
  logic pad_rst, pads_float, core_rail_ok, pad_rail_ok;
  int err_total = 0;
  int compares = 0;
  int cyc = 0;
  int wait_n;

  // -----------------------------------------------------------------
  // clock, instances, hang guard
  // -----------------------------------------------------------------
  initial begin
    forever #4 sys_clk = ~sys_clk;
  end

  aoncp_top #(.WAKE_W(2), .BKP_N(4), .OSC_START_CYC(OSC_N),
    .PDN_CYC(STG_N), .SUP_CYC(STG_N), .CLK_CYC(STG_N)) i_aoncp_top (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .clksel_pad(clksel_pad), .wake_pad(wake_pad),
    .wfi_exec(wfi_exec), .local_irq(irq_src[0]), .plat_irq(irq_src[1]),
    .other_wake(irq_src[2]), .pipe_clk_gate(pipe_clk_gate),
    .slow_osc_div(slow_osc_div), .slow_osc_trim(slow_osc_trim),
    .slow_osc_en(slow_osc_en), .slow_clk_use_ext(slow_clk_use_ext),
    .fast_osc_default(fast_osc_default), .pmu_out_0(pmu_out_0),
    .pmu_out_1(pmu_out_1), .clk_rst(clk_rst), .core_rst(core_rst),
    .pad_rst(pad_rst), .pads_float(pads_float));

  aoncp_board_model #(.WAKE_W(2), .RAMP_CYC(3)) i_aoncp_board_model (
    .sys_clk(sys_clk), .pmu_out_0(pmu_out_0), .pmu_out_1(pmu_out_1),
    .pad_low(pad_low), .wake_btn(wake_btn), .clksel_pad(clksel_pad),
    .wake_pad(wake_pad), .core_rail_ok(core_rail_ok),
    .pad_rail_ok(pad_rail_ok));

  // cut a hang short
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      err_total++;
      tally_and_finish();
    end
  end

  // -----------------------------------------------------------------
  // compare and bus tasks
  // -----------------------------------------------------------------
  task automatic cmp32(input logic [31:0] got, input logic [31:0] exp,
    input string m);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task automatic cmp1(input logic got, input logic exp, input string m);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t %s got %b exp %b", $time, m, got, exp);
    end
  endtask

  task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask

  // data stand only in the cycle after the strobe
  task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask

  task automatic read_chk(input logic [7:0] a, input logic [31:0] exp,
    input logic [31:0] msk, input string m);
    logic [31:0] d;
    reg_read(a, d);
    cmp32(d & msk, exp, m);
  endtask

  task automatic ticks(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  // bounded wait for a level, then compare it
  task automatic wait_lvl(ref logic s, input logic v, input int lim,
    input string m);
    wait_n = 0;
    while (s !== v && wait_n < lim) begin
      @(posedge sys_clk);
      #1;
      wait_n++;
    end
    cmp1(s, v, m);
  endtask

  task automatic tally_and_finish();
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // -----------------------------------------------------------------
  // test sequence
  // -----------------------------------------------------------------
  initial begin
    repeat (12) @(posedge sys_clk);
    sys_rst <= 1'b0;
    #1 cmp32({slow_osc_en, slow_osc_trim, slow_osc_div}, 32'h0000_0C04,
      "osc outputs after reset");
    ticks(OSC_N + 4);
    read_chk(`AONCP_OFS_OSC, 32'hC010_0004, 32'hFFFF_FFFF,
      "osc rst");
    reg_write(`AONCP_OFS_OSC, 32'hFFFF_FFFF);
    read_chk(`AONCP_OFS_OSC, 32'h401F_003F, 32'h7FFF_FFFF,
      "osc all");
    cmp32({slow_osc_trim, slow_osc_div}, 32'h0000_07FF,
      "osc outs");
    reg_write(`AONCP_OFS_OSC, 32'h0000_0004);
    ticks(OSC_N + 2);
    read_chk(`AONCP_OFS_OSC, 32'h0000_0004, 32'hFFFF_FFFF,
      "osc off");
    reg_write(`AONCP_OFS_OSC, 32'h4010_0004);
    read_chk(`AONCP_OFS_OSC, 32'h4010_0004, 32'hFFFF_FFFF,
      "osc start");
    ticks(OSC_N + 2);
    read_chk(`AONCP_OFS_OSC, 32'hC010_0004, 32'hFFFF_FFFF, "osc rdy");
    // slow clock source: pad strap and software select
    read_chk(`AONCP_OFS_MUX, 32'h8000_0000, 32'hFFFF_FFFF,
      "mux pad hi");
    cmp1(slow_clk_use_ext, 1'b0, "osc source");
    @(posedge sys_clk);
    pad_low <= 1'b1;
    ticks(6);
    cmp1(slow_clk_use_ext, 1'b1, "pad source");
    read_chk(`AONCP_OFS_MUX, 32'h0000_0000, 32'hFFFF_FFFF,
      "mux pad lo");
    @(posedge sys_clk);
    pad_low <= 1'b0;
    ticks(6);
    cmp1(slow_clk_use_ext, 1'b0, "back to osc");
    reg_write(`AONCP_OFS_MUX, 32'hFFFF_FFFF);
    ticks(2);
    cmp1(slow_clk_use_ext, 1'b1, "sw select");
    read_chk(`AONCP_OFS_MUX, 32'h8000_0001, 32'hFFFF_FFFF,
      "mux sw");
    reg_write(`AONCP_OFS_MUX, 32'h0000_0000);
    reg_write(8'h40, 32'hFFFF_FFFF);
    read_chk(8'h40, 32'h0000_0000, 32'hFFFF_FFFF, "unmapped");
    // wait mode left by each wake source in turn
    for (int k = 0; k < 3; k++) begin
      @(posedge sys_clk);
      wfi_exec <= 1'b1;
      irq_src <= 3'h0;
      @(posedge sys_clk);
      wfi_exec <= 1'b0;
      #1 cmp1(pipe_clk_gate, 1'b1, "wfi gates");
      ticks(3);
      cmp1(pipe_clk_gate, 1'b1, "gate holds");
      @(posedge sys_clk);
      irq_src <= 3'b001 << k;
      @(posedge sys_clk);
      #1 cmp1(pipe_clk_gate, 1'b0, "irq resumes");
    end
    @(posedge sys_clk);
    wfi_exec <= 1'b1;
    irq_src <= 3'h2;
    @(posedge sys_clk);
    wfi_exec <= 1'b0;
    irq_src <= 3'h0;
    #1 cmp1(pipe_clk_gate, 1'b0, "pending irq");
    // keyed sleep entry: refused attempts first
    reg_write(`AONCP_OFS_BKP, 32'hA5A5_5A5A);
    reg_write(`AONCP_OFS_WAKEEN, 32'h0000_0001);
    reg_write(`AONCP_OFS_SLEEP, 32'h0000_0000);
    ticks(STG_N + 4);
    cmp1(pmu_out_0, 1'b1, "no key");
    reg_write(`AONCP_OFS_KEY, `AONCP_KEY_VAL);
    reg_write(8'h94, 32'h0000_0000);
    reg_write(`AONCP_OFS_SLEEP, 32'h0000_0000);
    ticks(STG_N + 4);
    cmp1(core_rst, 1'b0, "key disarmed");
    reg_write(`AONCP_OFS_KEY, `AONCP_KEY_VAL);
    reg_read(`AONCP_OFS_STAT, rd_val);
    cmp32(rd_val & 32'h0000_001F, 32'h0000_0000, "stat idle");
    reg_write(`AONCP_OFS_SLEEP, 32'h0000_0000);
    wait_lvl(core_rst, 1'b1, 4, "pdown resets");
    cmp1(pad_rst & clk_rst, 1'b1, "pdown all rst");
    wait_lvl(pmu_out_0, 1'b0, STG_N + 4, "core off");
    ticks(STG_N);
    cmp1(pmu_out_1 | core_rail_ok, 1'b0, "pads off");
    cmp1(pads_float, 1'b1, "float");
    @(posedge sys_clk);
    wake_btn <= 2'b10;
    ticks(8);
    cmp1(pmu_out_0, 1'b0, "disabled wake");
    @(posedge sys_clk);
    wake_btn <= 2'b01;
    wait_lvl(pmu_out_0, 1'b1, 6, "wake supply");
    cmp1(pmu_out_1, 1'b1, "pad supply");
    cmp1(clk_rst & core_rst & pad_rst, 1'b1, "rst held");
    cmp1(fast_osc_default, 1'b1, "fast osc dflt");
    @(posedge sys_clk);
    wake_btn <= 2'b00;
    wait_lvl(clk_rst, 1'b0, STG_N + 4, "clk rst off");
    cmp1(core_rst & pad_rst, 1'b1, "core still rst");
    cmp1(core_rail_ok & pad_rail_ok, 1'b1, "rails up");
    wait_lvl(core_rst, 1'b0, STG_N + 4, "core rst off");
    cmp1(wait_n >= STG_N - 1 && wait_n <= STG_N + 1, 1'b1,
      "clk stage");
    cmp1(pad_rst | pads_float, 1'b0, "pads live");
    read_chk(`AONCP_OFS_CAUSE, 32'h0000_0001, 32'h0000_0003, "cause");
    read_chk(`AONCP_OFS_BKP, 32'hA5A5_5A5A, 32'hFFFF_FFFF, "backup");
    tally_and_finish();
  end
endmodule // tb

/* File: verilog/aoncp_consts.svh */
/*
  Constants of the always-on clock and power controller: register
  offsets, field positions, reset values, key value and stage counts.
  Assumes a byte-addressed register port with 8-bit addresses.
*/
// Contract
// - power-on reset sets slow oscillator trim to 16 and divider to 4
// - divider field is read-write bits 5:0, resets to 0x4
// - trim field is read-write bits 20:16, resets to 0x10
// - bit 30 read-write enable resets to one; bit 31 read-only ready
// - select pad low or mux bit 0 picks the external slow clock
// - mux register bit 31 reads the select pad level
// - on external reset slow clock comes from oscillator or pad per pad
// - on wakeup reset fast clock runs from fast oscillator default
// - wait-for-interrupt halts execution and gates pipeline clocks
// - local or platform interrupt, or other event, ends wait mode
// - accepted sleep powers down core and pads, outputs float
// - wakeup turns supplies on with clock, core, pad resets held
// - supplies stable releases clock reset; clocks stable releases others
// - readable cause register; backup registers survive sleep
// - supplies switch only through two dedicated chip outputs
`ifndef AONCP_CONSTS_SVH
`define AONCP_CONSTS_SVH

// -----------------------------------------------------------------
// register offsets
// -----------------------------------------------------------------
`define AONCP_OFS_OSC 8'h70
`define AONCP_OFS_MUX 8'h7C
`define AONCP_OFS_KEY 8'h80
`define AONCP_OFS_SLEEP 8'h84
`define AONCP_OFS_CAUSE 8'h88
`define AONCP_OFS_WAKEEN 8'h8C
`define AONCP_OFS_BKP 8'h90
`define AONCP_OFS_STAT 8'hA0

// -----------------------------------------------------------------
// fields and reset values
// -----------------------------------------------------------------
`define AONCP_DIV_MSB 5
`define AONCP_TRIM_LSB 16
`define AONCP_TRIM_MSB 20
`define AONCP_EN_BIT 30
`define AONCP_RDY_BIT 31
`define AONCP_DIV_RST 6'h04
`define AONCP_TRIM_RST 5'h10
`define AONCP_EN_RST 1'b1
`define AONCP_MUX_SEL_BIT 0
`define AONCP_MUX_STAT_BIT 31
`define AONCP_MUX_RST 1'b0
`define AONCP_KEY_VAL 32'h0051_F15E
`define AONCP_CAUSE_POR 2'h0
`define AONCP_CAUSE_WAKE 2'h1

// -----------------------------------------------------------------
// stage counts in slow-clock cycles
// -----------------------------------------------------------------
`define AONCP_OSC_START_CYC 16
`define AONCP_PDN_CYC 8
`define AONCP_SUP_CYC 32
`define AONCP_CLK_CYC 32

`endif

/* File: verilog/aoncp_pkg.sv */
/*
  Types of the always-on clock and power controller.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package aoncp_pkg;
  typedef enum logic [2:0] {
    st_run = 3'b000,
    st_pdown = 3'b001,
    st_sleep = 3'b010,
    st_pwrup = 3'b011,
    st_clkup = 3'b100
  } aoncp_state_t;
endpackage

/* File: verilog/aoncp_pwr_seq.sv */
/*
  Power-down and staged wakeup sequencer.
  Assumes wake events arrive already synchronised and gated by enable.
*/
`timescale 1ns/1ps
`include "aoncp_consts.svh"
module aoncp_pwr_seq
  import aoncp_pkg::*;
#(
  parameter int PDN_CYC = `AONCP_PDN_CYC,
  parameter int SUP_CYC = `AONCP_SUP_CYC,
  parameter int CLK_CYC = `AONCP_CLK_CYC
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  aoncp_seq_if.seq sq
);
  aoncp_state_t state_q;
  logic [7:0] cnt_q;
  logic done_d;

  // -----------------------------------------------------------------
  // stage sequencing
  // -----------------------------------------------------------------
  // stage timer expiry
  function automatic logic hit(input logic [7:0] c, input int n);
    hit = (c == 8'(n - 1));
  endfunction

  always_comb begin
    done_d = 1'b0;
    case (state_q)
      st_pdown: done_d = hit(cnt_q, PDN_CYC);
      st_pwrup: done_d = hit(cnt_q, SUP_CYC);
      st_clkup: done_d = hit(cnt_q, CLK_CYC);
      default: done_d = 1'b0;
    endcase
  end

  // state walk, each stage timed in slow cycles
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      state_q <= st_run;
    end else begin
      case (state_q)
        st_run: if (sq.sleep_req) state_q <= st_pdown;
        st_pdown: if (done_d) state_q <= st_sleep;
        st_sleep: if (|sq.wake_evt) state_q <= st_pwrup;
        st_pwrup: if (done_d) state_q <= st_clkup;
        st_clkup: if (done_d) state_q <= st_run;
        default: state_q <= st_run;
      endcase
    end
  end

  // stage counter, cleared on every stage change
  always_ff @(posedge sys_clk) begin
    if (sys_rst || done_d || state_q == st_run || state_q == st_sleep) begin
      cnt_q <= 8'h00;
    end else begin
      cnt_q <= cnt_q + 8'h01;
    end
  end

  // -----------------------------------------------------------------
  // supply and reset outputs
  // -----------------------------------------------------------------
  // supplies on except in sleep and power-down
  assign sq.core_sup_en = (state_q != st_sleep) && (state_q != st_pdown);
  assign sq.pad_sup_en = sq.core_sup_en;
  assign sq.clk_rst = (state_q != st_run) && (state_q != st_clkup);
  assign sq.core_rst = (state_q != st_run);
  assign sq.pad_rst = (state_q != st_run);
  assign sq.pads_float = (state_q == st_sleep) || (state_q == st_pdown);
  assign sq.wake_done = (state_q == st_clkup) && done_d;
  assign sq.state = state_q;

  sequence wake_start;
    state_q == st_sleep ##1 state_q == st_pwrup;
  endsequence

  AST_WAKE_RESETS: assert property (@(posedge sys_clk)
    disable iff (sys_rst)
    wake_start |-> sq.core_sup_en && sq.clk_rst && sq.core_rst
      && sq.pad_rst)
    else $error("wakeup without supplies on and resets held");
  AST_CLKRST_FIRST: assert property (@(posedge sys_clk)
    disable iff (sys_rst)
    $fell(sq.clk_rst) |-> sq.core_rst ##CLK_CYC !sq.core_rst)
    else $error("core reset not released one clock stage later");
  AST_WAKE_DONE: assert property (@(posedge sys_clk)
    disable iff (sys_rst)
    sq.wake_done |=> !sq.core_rst && !sq.pad_rst)
    else $error("resets still held after clock stage");
endmodule // aoncp_pwr_seq

/* File: verilog/aoncp_seq_if.sv */
/*
  Link between the register side and the power sequencer.
  Assumes both ends run on the same slow always-on clock.
*/
`timescale 1ns/1ps
interface aoncp_seq_if #(parameter int WAKE_W = 2);
  import aoncp_pkg::*;
  logic sleep_req;
  logic [WAKE_W-1:0] wake_evt;
  logic core_sup_en;
  logic pad_sup_en;
  logic clk_rst;
  logic core_rst;
  logic pad_rst;
  logic pads_float;
  logic wake_done;
  aoncp_state_t state;
  modport ctl (output sleep_req, output wake_evt, input core_sup_en,
    input pad_sup_en, input clk_rst, input core_rst, input pad_rst,
    input pads_float, input wake_done, input state);
  modport seq (input sleep_req, input wake_evt, output core_sup_en,
    output pad_sup_en, output clk_rst, output core_rst, output pad_rst,
    output pads_float, output wake_done, output state);
endinterface

/* File: verilog/aoncp_top.sv */
/*
  Always-on clock and power controller: slow oscillator configuration,
  slow clock source mux, wait mode, keyed sleep entry and wakeup.
  Assumes a single-cycle register port and a free-running slow clock.
*/
`timescale 1ns/1ps
`include "aoncp_consts.svh"
module aoncp_top
  import aoncp_pkg::*;
#(
  parameter int WAKE_W = 2,
  parameter int BKP_N = 4,
  parameter int OSC_START_CYC = `AONCP_OSC_START_CYC,
  parameter int PDN_CYC = `AONCP_PDN_CYC,
  parameter int SUP_CYC = `AONCP_SUP_CYC,
  parameter int CLK_CYC = `AONCP_CLK_CYC
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic clksel_pad,
  input wire logic [WAKE_W-1:0] wake_pad,
  input wire logic wfi_exec,
  input wire logic local_irq,
  input wire logic plat_irq,
  input wire logic other_wake,
  output logic pipe_clk_gate,
  output logic [5:0] slow_osc_div,
  output logic [4:0] slow_osc_trim,
  output logic slow_osc_en,
  output logic slow_clk_use_ext,
  output logic fast_osc_default,
  output logic pmu_out_0,
  output logic pmu_out_1,
  output logic clk_rst,
  output logic core_rst,
  output logic pad_rst,
  output logic pads_float
);
  aoncp_seq_if #(.WAKE_W(WAKE_W)) sif ();

  logic [5:0] div_q;
  logic [4:0] trim_q;
  logic en_q;
  logic rdy_q;
  logic [7:0] start_q;
  logic ext_sel_q;
  logic use_ext_q;
  logic sel_s1_q;
  logic sel_s2_q;
  logic [WAKE_W-1:0] wk_s1_q;
  logic [WAKE_W-1:0] wk_s2_q;
  logic [WAKE_W-1:0] wake_en_q;
  logic unlock_q;
  logic sleep_req_q;
  logic [1:0] cause_code_q;
  logic [WAKE_W-1:0] cause_evt_q;
  logic [31:0] bkp_q [BKP_N];
  logic wait_q;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic irq_any;

  // word index of a backup register, or BKP_N when not one
  function automatic int bkp_idx(input logic [7:0] a);
    bkp_idx = BKP_N;
    for (int i = 0; i < BKP_N; i++) begin
      if (a == 8'(`AONCP_OFS_BKP + 4 * i)) bkp_idx = i;
    end
  endfunction

  // write strobe aimed at one offset
  function automatic logic wr_at(input logic [7:0] ofs);
    wr_at = reg_wr && (reg_addr == ofs);
  endfunction

  // -----------------------------------------------------------------
  // pin synchronisers
  // -----------------------------------------------------------------
  // select pad and wake pins pass two flip-flops
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      sel_s1_q <= 1'b1;
      sel_s2_q <= 1'b1;
      wk_s1_q <= '0;
      wk_s2_q <= '0;
    end else begin
      sel_s1_q <= clksel_pad;
      sel_s2_q <= sel_s1_q;
      wk_s1_q <= wake_pad;
      wk_s2_q <= wk_s1_q;
    end
  end

  // -----------------------------------------------------------------
  // slow oscillator configuration
  // -----------------------------------------------------------------
  // divider, trim and enable fields
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      div_q <= `AONCP_DIV_RST;
      trim_q <= `AONCP_TRIM_RST;
      en_q <= `AONCP_EN_RST;
    end else if (wr_at(`AONCP_OFS_OSC)) begin
      div_q <= reg_wdata[`AONCP_DIV_MSB:0];
      trim_q <= reg_wdata[`AONCP_TRIM_MSB:`AONCP_TRIM_LSB];
      en_q <= reg_wdata[`AONCP_EN_BIT];
    end
  end

  // start-up timer behind the ready flag
  always_ff @(posedge sys_clk) begin
    if (sys_rst || !en_q) begin
      start_q <= 8'h00;
      rdy_q <= 1'b0;
    end else if (start_q == 8'(OSC_START_CYC - 1)) begin
      rdy_q <= 1'b1;
    end else begin
      start_q <= start_q + 8'h01;
    end
  end

  assign slow_osc_div = div_q;
  assign slow_osc_trim = trim_q;
  assign slow_osc_en = en_q;

  // -----------------------------------------------------------------
  // slow clock source mux
  // -----------------------------------------------------------------
  // software select bit
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      ext_sel_q <= `AONCP_MUX_RST;
    end else if (wr_at(`AONCP_OFS_MUX)) begin
      ext_sel_q <= reg_wdata[`AONCP_MUX_SEL_BIT];
    end
  end

  // pad low or software bit picks the external pad clock
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      use_ext_q <= 1'b0;
    end else begin
      use_ext_q <= !sel_s2_q || ext_sel_q;
    end
  end

  assign slow_clk_use_ext = use_ext_q;

  // -----------------------------------------------------------------
  // wait mode
  // -----------------------------------------------------------------
  assign irq_any = local_irq || plat_irq || other_wake;

  // wfi gates the pipeline until an interrupt or event
  always_ff @(posedge sys_clk) begin
    if (sys_rst || core_rst) begin
      wait_q <= 1'b0;
    end else if (wait_q && irq_any) begin
      wait_q <= 1'b0;
    end else if (wfi_exec && !irq_any) begin
      wait_q <= 1'b1;
    end
  end

  assign pipe_clk_gate = wait_q;

  // -----------------------------------------------------------------
  // keyed sleep entry
  // -----------------------------------------------------------------
  // key arms the very next write only
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      unlock_q <= 1'b0;
      sleep_req_q <= 1'b0;
    end else begin
      sleep_req_q <= 1'b0;
      if (reg_wr) begin
        unlock_q <= wr_at(`AONCP_OFS_KEY)
          && (reg_wdata == `AONCP_KEY_VAL);
        sleep_req_q <= wr_at(`AONCP_OFS_SLEEP) && unlock_q;
      end
    end
  end

  // wake enables
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      wake_en_q <= '0;
    end else if (wr_at(`AONCP_OFS_WAKEEN)) begin
      wake_en_q <= reg_wdata[WAKE_W-1:0];
    end
  end

  assign sif.sleep_req = sleep_req_q;
  assign sif.wake_evt = wk_s2_q & wake_en_q;

  aoncp_pwr_seq #(
    .PDN_CYC(PDN_CYC),
    .SUP_CYC(SUP_CYC),
    .CLK_CYC(CLK_CYC)
  ) u_seq (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .sq(sif.seq)
  );

  assign pmu_out_0 = sif.core_sup_en;
  assign pmu_out_1 = sif.pad_sup_en;
  assign clk_rst = sif.clk_rst;
  assign core_rst = sif.core_rst;
  assign pad_rst = sif.pad_rst;
  assign pads_float = sif.pads_float;
  assign fast_osc_default = sif.clk_rst;

  // -----------------------------------------------------------------
  // cause and backup registers
  // -----------------------------------------------------------------
  // cause records power-on or the wake events that ended sleep
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      cause_code_q <= `AONCP_CAUSE_POR;
      cause_evt_q <= '0;
    end else if (sif.state == st_sleep && |sif.wake_evt) begin
      cause_code_q <= `AONCP_CAUSE_WAKE;
      cause_evt_q <= sif.wake_evt;
    end
  end

  // backup words, untouched by the sleep sequence
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      for (int i = 0; i < BKP_N; i++) bkp_q[i] <= 32'h0000_0000;
    end else if (reg_wr && bkp_idx(reg_addr) < BKP_N) begin
      bkp_q[bkp_idx(reg_addr)] <= reg_wdata;
    end
  end

  // -----------------------------------------------------------------
  // register read path
  // -----------------------------------------------------------------
  // read mux, unmapped offsets read zero
  always_comb begin
    rdata_d = 32'h0000_0000;
    if (reg_addr == `AONCP_OFS_OSC) begin
      rdata_d[`AONCP_DIV_MSB:0] = div_q;
      rdata_d[`AONCP_TRIM_MSB:`AONCP_TRIM_LSB] = trim_q;
      rdata_d[`AONCP_EN_BIT] = en_q;
      rdata_d[`AONCP_RDY_BIT] = rdy_q;
    end else if (reg_addr == `AONCP_OFS_MUX) begin
      rdata_d[`AONCP_MUX_SEL_BIT] = ext_sel_q;
      rdata_d[`AONCP_MUX_STAT_BIT] = sel_s2_q;
    end else if (reg_addr == `AONCP_OFS_CAUSE) begin
      rdata_d[1:0] = cause_code_q;
      rdata_d[8 +: WAKE_W] = cause_evt_q;
    end else if (reg_addr == `AONCP_OFS_WAKEEN) begin
      rdata_d[WAKE_W-1:0] = wake_en_q;
    end else if (reg_addr == `AONCP_OFS_STAT) begin
      rdata_d[2:0] = sif.state;
      rdata_d[4] = wait_q;
    end else if (bkp_idx(reg_addr) < BKP_N) begin
      rdata_d = bkp_q[bkp_idx(reg_addr)];
    end
  end

  // read data stands the cycle after the strobe only
  always_ff @(posedge sys_clk) begin
    if (sys_rst || !reg_rd) begin
      rdata_q <= 32'h0000_0000;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata = rdata_q;

  // -----------------------------------------------------------------
  // checks
  // -----------------------------------------------------------------
  sequence keyed_sleep;
    wr_at(`AONCP_OFS_KEY) && reg_wdata == `AONCP_KEY_VAL
      ##1 wr_at(`AONCP_OFS_SLEEP);
  endsequence

  AST_OSC_RESET: assert property (@(posedge sys_clk)
    sys_rst |=> div_q == 6'h04 && trim_q == 5'h10 && en_q)
    else $error("slow oscillator reset values wrong");
  AST_KEYED_SLEEP: assert property (@(posedge sys_clk)
    disable iff (sys_rst) keyed_sleep |=> sleep_req_q)
    else $error("keyed sleep write not accepted");
  AST_UNKEYED_SLEEP: assert property (@(posedge sys_clk)
    disable iff (sys_rst)
    wr_at(`AONCP_OFS_SLEEP) && !unlock_q |=> !sleep_req_q)
    else $error("sleep write accepted without key");
  AST_RDY_OFF: assert property (@(posedge sys_clk)
    disable iff (sys_rst) !en_q |=> !rdy_q)
    else $error("ready flag set while oscillator disabled");
  AST_RDY_DELAY: assert property (@(posedge sys_clk)
    disable iff (sys_rst) $rose(en_q) |-> !rdy_q [*8])
    else $error("ready flag rose too early");
  AST_MUX_STAT: assert property (@(posedge sys_clk)
    disable iff (sys_rst)
    reg_rd && reg_addr == `AONCP_OFS_MUX |=> reg_rdata[31] == $past(sel_s2_q))
    else $error("mux status bit does not follow select pad");
  AST_EXT_SEL: assert property (@(posedge sys_clk)
    disable iff (sys_rst)
    ##1 !$past(sel_s2_q) |-> slow_clk_use_ext)
    else $error("select pad low did not pick pad clock");
  AST_WFI_GATE: assert property (@(posedge sys_clk)
    disable iff (sys_rst)
    wfi_exec && !irq_any && !core_rst |=> pipe_clk_gate)
    else $error("wfi did not gate pipeline clocks");
  AST_IRQ_RESUME: assert property (@(posedge sys_clk)
    disable iff (sys_rst) pipe_clk_gate && irq_any |=> !pipe_clk_gate)
    else $error("interrupt did not end wait mode");
  AST_SLEEP_OFF: assert property (@(posedge sys_clk)
    disable iff (sys_rst) sleep_req_q |=> ##PDN_CYC !pmu_out_0 && pads_float)
    else $error("supplies not off after power-down stage");
  AST_FAST_DEFAULT: assert property (@(posedge sys_clk)
    disable iff (sys_rst) sif.state == st_pwrup |-> fast_osc_default)
    else $error("fast clock not forced to default during wake reset");
endmodule // aoncp_top
